// file: rtl/ibcb_master.sv
// Decided for this implementation: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps
module ibcb_master
#(
    parameter int QTR = ibcb_pkg::QTR_CYC
)
(
    // Clock and reset
    input  wire logic               ref_clk,
    input  wire logic               rst,
    // Avalon-MM slave
    input  wire ibcb_pkg::ibcb_addr_t avs_address,
    input  wire logic               avs_read,
    input  wire logic               avs_write,
    input  wire ibcb_pkg::ibcb_word_t avs_writedata,
    output ibcb_pkg::ibcb_word_t    avs_readdata,
    output logic                    avs_waitrequest,
    // Open-drain bus pins
    input  wire ibcb_pkg::ibcb_pins_s pin_in,
    output ibcb_pkg::ibcb_pins_s    pin_out,
    output ibcb_pkg::ibcb_pins_s    pin_oe
);
    import ibcb_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers: a change counts once stages two and three agree.

    logic [1:0] s1_q;
    logic [1:0] s2_q;
    logic [1:0] s3_q;
    logic [1:0] f_q;
    logic       sda_p_q;

    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : g_sync
            always_ff @(posedge ref_clk or posedge rst)
            begin
                if (rst)
                begin
                    s1_q[g] <= 1'b1;
                    s2_q[g] <= 1'b1;
                    s3_q[g] <= 1'b1;
                    f_q[g]  <= 1'b1;
                end
                else
                begin
                    s1_q[g] <= (g == 0) ? pin_in.sda : pin_in.scl;
                    s2_q[g] <= s1_q[g];
                    s3_q[g] <= s2_q[g];
                    f_q[g]  <= (s2_q[g] == s3_q[g]) ? s3_q[g] : f_q[g];
                end
            end
        end
    endgenerate

    wire sda_s = f_q[0];
    wire scl_s = f_q[1];

    ////////////////////////////////////////////////////////////////////////////
    // Bus monitor. Data edges with the clock high are conditions only.

    logic busy_bus_q;
    wire  start_det = scl_s && sda_p_q && !sda_s;
    wire  stop_det  = scl_s && !sda_p_q && sda_s;

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            sda_p_q    <= 1'b1;
            busy_bus_q <= 1'b0;
        end
        else
        begin
            sda_p_q <= sda_s;
            if (start_det)
                busy_bus_q <= 1'b1;
            else if (stop_det)
                busy_bus_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers and Avalon slave. The answer comes one cycle after the request.

    ibcb_state_e st_q;
    logic        en_q;
    logic [7:0]  tx_q;
    logic [7:0]  sh_q;
    logic [7:0]  rx_q;
    logic        rd_q;
    logic        nack_tx_q;
    logic        nack_rx_q;
    logic        arb_q;
    logic        own_q;
    logic        do_start_q;
    logic        do_byte_q;
    logic        do_stop_q;
    logic        wait_q;
    ibcb_word_t  rdata_q;

    wire busy   = (st_q != ST_IDLE) || do_start_q || do_byte_q || do_stop_q;
    wire wr_ok  = avs_write && !wait_q;
    wire wr_cmd = wr_ok && (avs_address == ADDR_CMD) && en_q && !busy;

    wire [31:0] stat_word = {27'h0, own_q, nack_rx_q, arb_q, busy_bus_q, busy};
    wire [31:0] rd_mux =
        (avs_address == ADDR_CTRL)   ? {31'h0, en_q} :
        (avs_address == ADDR_TXDATA) ? {24'h0, tx_q} :
        (avs_address == ADDR_STATUS) ? stat_word :
        (avs_address == ADDR_RXDATA) ? {24'h0, rx_q} : 32'h0;

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            wait_q  <= 1'b1;
            rdata_q <= 32'h0;
            en_q    <= 1'b0;
            tx_q    <= RST_BYTE;
        end
        else
        begin
            wait_q <= !((avs_read || avs_write) && wait_q);
            if ((avs_read || avs_write) && wait_q)
                rdata_q <= rd_mux;
            if (wr_ok && avs_address == ADDR_CTRL)
                en_q <= avs_writedata[CTRL_EN];
            if (wr_ok && avs_address == ADDR_TXDATA)
                tx_q <= avs_writedata[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bit engine. Each bit is four quarter phases; phase 2 waits for clock high.
    // The quarter must outlast the four-cycle pin synchroniser, or a Stop reads as lost.

    logic [15:0] cnt_q;
    logic [1:0]  ph_q;
    logic [3:0]  bit_q;
    logic        scl_oe_q;
    logic        sda_oe_q;
    logic        sda_o_q;

    wire tick     = (cnt_q == 16'h0000);
    wire adv      = tick && ((ph_q != 2'd2) || scl_s);
    wire ack_bit  = (bit_q == 4'(BITS_BYTE));
    wire want_low = ack_bit ? (rd_q && !nack_tx_q) : (!rd_q && !sh_q[7]);
    wire lost_bit = (st_q == ST_BIT) && adv && ph_q == 2'd2 && !ack_bit && !rd_q && sh_q[7] && !sda_s;
    wire lost_cond = ((st_q == ST_START) && adv && ph_q == 2'd2 && !sda_s) ||
                     ((st_q == ST_STOP) && adv && ph_q == 2'd3 && !sda_s);
    wire lost     = lost_bit || lost_cond;
    wire may_start = !busy_bus_q || own_q;

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            cnt_q <= 16'h0000;
        else
            cnt_q <= (tick || st_q == ST_IDLE) ? 16'(QTR - 1) : cnt_q - 16'h0001;
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            st_q       <= ST_IDLE;
            ph_q       <= 2'd0;
            bit_q      <= 4'h0;
            sh_q       <= RST_BYTE;
            rx_q       <= RST_BYTE;
            rd_q       <= 1'b0;
            nack_tx_q  <= 1'b0;
            nack_rx_q  <= 1'b0;
            arb_q      <= 1'b0;
            own_q      <= 1'b0;
            do_start_q <= 1'b0;
            do_byte_q  <= 1'b0;
            do_stop_q  <= 1'b0;
            scl_oe_q   <= 1'b0;
            sda_oe_q   <= 1'b0;
            sda_o_q    <= 1'b0;
        end
        else if (!en_q)
        begin
            st_q       <= ST_IDLE;
            ph_q       <= 2'd0;
            own_q      <= 1'b0;
            do_start_q <= 1'b0;
            do_byte_q  <= 1'b0;
            do_stop_q  <= 1'b0;
            scl_oe_q   <= 1'b0;
            sda_oe_q   <= 1'b0;
        end
        else
        begin
            sda_o_q <= 1'b0;
            if (wr_cmd)
            begin
                do_start_q <= avs_writedata[CMD_START];
                do_byte_q  <= avs_writedata[CMD_BYTE];
                do_stop_q  <= avs_writedata[CMD_STOP];
                rd_q       <= avs_writedata[CMD_READ];
                nack_tx_q  <= avs_writedata[CMD_NACK];
                sh_q       <= tx_q;
                arb_q      <= 1'b0;
            end
            if (lost)
            begin
                // Losing releases both lines at once; software retries after Stop.
                st_q       <= ST_IDLE;
                ph_q       <= 2'd0;
                own_q      <= 1'b0;
                arb_q      <= 1'b1;
                do_byte_q  <= 1'b0;
                do_stop_q  <= 1'b0;
                scl_oe_q   <= 1'b0;
                sda_oe_q   <= 1'b0;
            end
            else
            begin
                case (st_q)
                    ST_IDLE:
                    begin
                        ph_q <= 2'd0;
                        if (do_start_q && may_start)
                        begin
                            st_q       <= ST_START;
                            do_start_q <= 1'b0;
                        end
                        else if (!do_start_q && do_byte_q)
                        begin
                            st_q      <= ST_BIT;
                            bit_q     <= 4'h0;
                            do_byte_q <= 1'b0;
                        end
                        else if (!do_start_q && do_stop_q)
                        begin
                            st_q      <= ST_STOP;
                            do_stop_q <= 1'b0;
                        end
                    end
                    ST_START:
                    begin
                        if (adv)
                        begin
                            ph_q <= ph_q + 2'd1;
                            case (ph_q)
                                2'd0:    sda_oe_q <= 1'b0;
                                2'd1:    scl_oe_q <= 1'b0;
                                2'd2:    sda_oe_q <= 1'b1;
                                default:
                                begin
                                    scl_oe_q <= 1'b1;
                                    own_q    <= 1'b1;
                                    st_q     <= ST_IDLE;
                                end
                            endcase
                        end
                    end
                    ST_BIT:
                    begin
                        if (adv)
                        begin
                            ph_q <= ph_q + 2'd1;
                            case (ph_q)
                                2'd0:    sda_oe_q <= want_low;
                                2'd1:    scl_oe_q <= 1'b0;
                                2'd2:
                                begin
                                    // Sample at the end of phase 2 with the clock seen high; a clean compare keeps going.
                                    if (ack_bit && !rd_q)
                                        nack_rx_q <= sda_s;
                                    else if (!ack_bit)
                                        sh_q <= {sh_q[6:0], sda_s};
                                end
                                default:
                                begin
                                    scl_oe_q <= 1'b1;
                                    bit_q    <= bit_q + 4'h1;
                                    if (ack_bit)
                                    begin
                                        rx_q  <= sh_q;
                                        bit_q <= 4'h0;
                                        st_q  <= ST_IDLE;
                                    end
                                end
                            endcase
                        end
                    end
                    ST_STOP:
                    begin
                        if (adv)
                        begin
                            ph_q <= ph_q + 2'd1;
                            case (ph_q)
                                2'd0:    sda_oe_q <= 1'b1;
                                2'd1:    scl_oe_q <= 1'b0;
                                2'd2:    sda_oe_q <= 1'b0;
                                default:
                                begin
                                    own_q <= 1'b0;
                                    st_q  <= ST_IDLE;
                                end
                            endcase
                        end
                    end
                    default: st_q <= ST_IDLE;
                endcase
            end
        end
    end

    assign avs_readdata    = rdata_q;
    assign avs_waitrequest = wait_q;
    assign pin_out.scl     = sda_o_q;
    assign pin_out.sda     = sda_o_q;
    assign pin_oe.scl      = scl_oe_q;
    assign pin_oe.sda      = sda_oe_q;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions.

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    sequence s_lost;
        lost && en_q;
    endsequence

    sequence s_released;
        !scl_oe_q && !sda_oe_q && arb_q;
    endsequence

    a_arb_release: assert property (s_lost |=> s_released)
        else $error("arbitration loss did not release both lines");
    a_data_zero: assert property (##1 !sda_o_q)
        else $error("pin output value not zero");
    a_start_idle: assert property ((st_q == ST_IDLE && $past(st_q) != ST_START && !own_q
                                    && busy_bus_q) |=> st_q != ST_START)
        else $error("start issued on busy bus");
    a_stretch_wait: assert property ((st_q == ST_BIT && ph_q == 2'd2 && !scl_s && !lost && en_q)
                                    |=> ph_q == 2'd2)
        else $error("phase advanced while clock held low");
    a_data_setup: assert property ((st_q == ST_BIT && $changed(sda_oe_q) && !lost)
                                   |-> $past(scl_oe_q))
        else $error("data changed with clock released");
    a_ack_release: assert property ((st_q == ST_BIT && ack_bit && !rd_q && ph_q == 2'd1)
                                    |-> !sda_oe_q)
        else $error("sender kept data during acknowledge");
    a_msb_first: assert property ((st_q == ST_BIT && bit_q == 4'h0 && ph_q == 2'd0 && adv && !rd_q)
                                  |=> sda_oe_q == !$past(sh_q[7]))
        else $error("first bit not most significant");
    a_nine_bits: assert property ((st_q == ST_BIT && $past(st_q) == ST_BIT) |-> bit_q <= 4'd8)
        else $error("byte longer than nine clocks");
    a_read_release: assert property ((st_q == ST_BIT && rd_q && !ack_bit && ph_q != 2'd0)
                                     |-> !sda_oe_q)
        else $error("master drove data during read byte");
    a_stop_busy: assert property (stop_det && !start_det |=> !busy_bus_q)
        else $error("bus stayed busy after stop");

endmodule : ibcb_master

// file: rtl/ibcb_pkg.sv
package ibcb_pkg;

    // Register byte addresses on the control bus.
    localparam logic [4:0] ADDR_CTRL   = 5'h00;
    localparam logic [4:0] ADDR_TXDATA = 5'h04;
    localparam logic [4:0] ADDR_CMD    = 5'h08;
    localparam logic [4:0] ADDR_STATUS = 5'h0C;
    localparam logic [4:0] ADDR_RXDATA = 5'h10;

    // Field positions.
    localparam int CTRL_EN      = 0;
    localparam int CMD_START    = 0;
    localparam int CMD_BYTE     = 1;
    localparam int CMD_READ     = 2;
    localparam int CMD_STOP     = 3;
    localparam int CMD_NACK     = 4;
    localparam int STAT_BUSY    = 0;
    localparam int STAT_BUSBUSY = 1;
    localparam int STAT_ARBLOST = 2;
    localparam int STAT_NACK    = 3;
    localparam int STAT_OWN     = 4;

    // Reset values.
    localparam logic [7:0] RST_BYTE = 8'h00;

    // Timing: one quarter of a bus bit period.
    localparam int CLK_NS     = 10;
    localparam int QTR_NS     = 2500;
    localparam int QTR_CYC    = (QTR_NS + CLK_NS - 1) / CLK_NS;
    localparam int BITS_BYTE  = 8;

    typedef logic [4:0]  ibcb_addr_t;
    typedef logic [31:0] ibcb_word_t;

    typedef enum logic [1:0]
    {
        ST_IDLE  = 2'b00,
        ST_START = 2'b01,
        ST_BIT   = 2'b11,
        ST_STOP  = 2'b10
    } ibcb_state_e;

    typedef struct packed
    {
        logic scl;
        logic sda;
    } ibcb_pins_s;

endpackage : ibcb_pkg

// file: sim/ibcb_slave_model.sv
`timescale 1ns/1ps
module ibcb_slave_model
#(
    parameter logic [6:0] SLV_ADDR = 7'h2A
)
(
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rst,
    // Resolved bus lines
    input  wire logic       scl,
    input  wire logic       sda,
    // Bench controls and observation
    input  wire logic [7:0] rd_byte,
    input  wire logic [7:0] stretch,
    output logic [7:0]      rx_byte,
    // Pulls, high drags the line low
    output logic            scl_oe,
    output logic            sda_oe
);
    logic       scl_q, sda_q, first_q, match_q, read_q, send_q;
    logic [3:0] bit_q;
    logic [7:0] sh_q, tx_q, hold_q;
    // Conditions count only with the clock high before and after the data edge.
    wire logic       rise  = scl & ~scl_q;
    wire logic       fall  = ~scl & scl_q;
    wire logic       start = scl & scl_q & sda_q & ~sda;
    wire logic       stop  = scl & scl_q & ~sda_q & sda;
    wire logic       hit   = sh_q[7:1] == SLV_ADDR;
    wire logic       drv   = match_q & read_q & send_q;
    wire logic [7:0] nxt   = tx_q + 8'h01;
////////////////////////////////////////
    // The pins are only ever pulled, so the output value is zero by construction.
    always @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            {scl_q, sda_q, scl_oe, sda_oe} <= 4'hC;
            {first_q, match_q, read_q, send_q} <= 4'h0;
            bit_q <= 4'hF;
            {sh_q, tx_q, hold_q, rx_byte} <= 32'h0;
        end
        else
        begin
            scl_q  <= scl;
            sda_q  <= sda;
            hold_q <= (hold_q != 8'h00) ? hold_q - 8'h01 : 8'h00;
            scl_oe <= hold_q > 8'h01;
            if (start)
            begin
                bit_q   <= 4'hF;
                first_q <= 1'b1;
                match_q <= 1'b0;
                sda_oe  <= 1'b0;
            end
            else if (stop)
            begin
                match_q <= 1'b0;
                sda_oe  <= 1'b0;
            end
            else if (rise && bit_q < 4'h8)
                sh_q <= {sh_q[6:0], sda};
            else if (rise && bit_q == 4'h8 && sda)
                send_q <= 1'b0;
            else if (fall)
            begin
                bit_q <= (bit_q >= 4'h8) ? 4'h0 : bit_q + 4'h1;
                if (bit_q == 4'h7)
                begin
                    first_q <= 1'b0;
                    if (first_q)
                        {match_q, read_q, send_q, tx_q} <= {hit, sh_q[0], sh_q[0], rd_byte - 8'h01};
                    else if (!read_q)
                        rx_byte <= sh_q;
                    // A reading slave lets go so that the master can answer.
                    sda_oe <= first_q ? hit : (match_q & ~read_q);
                end
                else if (bit_q == 4'h8)
                begin
                    tx_q   <= nxt;
                    hold_q <= stretch;
                    scl_oe <= stretch != 8'h00;
                    sda_oe <= drv & ~nxt[7];
                end
                else if (bit_q < 4'h7)
                    sda_oe <= drv & ~tx_q[3'h6 - bit_q[2:0]];
            end
        end
    end
endmodule : ibcb_slave_model

// file: sim/test_ibcb_master.sv
`timescale 1ns/1ps
module test_ibcb_master;
    import ibcb_pkg::*;
    localparam int         QTR_TB = 8;
    localparam logic [6:0] SLV    = 7'h2A;
    localparam ibcb_addr_t RST_ADDRS [4] = '{ADDR_CTRL, ADDR_STATUS, ADDR_RXDATA, 5'h14};
    logic        ref_clk, rst, avs_read, avs_write, avs_waitrequest;
    logic        m_scl_oe, m_sda_oe, tb_sda_oe;
    logic [7:0]  rd_byte, stretch, rx_byte;
    ibcb_addr_t  avs_address;
    ibcb_word_t  avs_writedata, avs_readdata, s;
    ibcb_pins_s  pin_in, pin_out, pin_oe;
    logic [31:0] seed;
    int          err_total, n_compared, i;
    // Any pull wins, otherwise the pull-up holds the line high.
    wire logic   scl = ~(pin_oe.scl | m_scl_oe);
    wire logic   sda = ~(pin_oe.sda | m_sda_oe | tb_sda_oe);
    assign pin_in = {scl, sda};

    ibcb_master #(.QTR(QTR_TB)) dut (.ref_clk(ref_clk), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));
    ibcb_slave_model #(.SLV_ADDR(SLV)) slave (.ref_clk(ref_clk), .rst(rst), .scl(scl), .sda(sda),
        .rd_byte(rd_byte), .stretch(stretch), .rx_byte(rx_byte), .scl_oe(m_scl_oe), .sda_oe(m_sda_oe));

    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] v);
        v = v ^ (v << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction : xs

    function automatic ibcb_word_t stat_exp(input logic bb, input logic arb, input logic nack, input logic own);
        ibcb_word_t w;
        w = 32'h0;
        w[STAT_BUSBUSY] = bb;
        w[STAT_ARBLOST] = arb;
        w[STAT_NACK]    = nack;
        w[STAT_OWN]     = own;
        return w;
    endfunction : stat_exp

    task automatic check_val(input string nm, input ibcb_word_t exp, input ibcb_word_t got);
        n_compared++;
        if (got !== exp)
        begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask : check_val

    task automatic complete_run();
        $display("Compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : complete_run

    // One bus cycle; the request stands until waitrequest is seen low, read data lands in s.
    task automatic bus(input logic wr, input ibcb_addr_t a, input ibcb_word_t d);
        @(posedge ref_clk);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= wr;
        avs_read      <= ~wr;
        do
            @(posedge ref_clk);
        while (avs_waitrequest !== 1'b0);
        s = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
    endtask : bus

    task automatic wait_idle();
        int n;
        s = 32'h1;
        for (n = 0; n < 3000 && s[STAT_BUSY] !== 1'b0; n++)
            bus(1'b0, ADDR_STATUS, 32'h0);
        check_val("engine busy", 32'h0, {31'h0, s[STAT_BUSY]});
    endtask : wait_idle

    task automatic cmd(input logic [7:0] tx, input logic [4:0] c);
        bus(1'b1, ADDR_TXDATA, {24'h0, tx});
        bus(1'b1, ADDR_CMD, {27'h0, c});
        wait_idle();
    endtask : cmd
////////////////////////////////////////
    // One write message, then a two-byte read message if the slave answers.
    task automatic round(input logic [6:0] a, input logic [7:0] d, input logic [7:0] r);
        logic ok;
        ok = (a == SLV);
        cmd({a, 1'b0}, 5'h03);
        check_val("status after address", stat_exp(1'b1, 1'b0, ~ok, 1'b1), s & 32'h1E);
        cmd(d, 5'h02);
        if (ok)
            check_val("byte at slave", {24'h0, d}, {24'h0, rx_byte});
        cmd(d, 5'h08);
        check_val("status after stop", 32'h0, s & 32'h16);
        if (!ok)
            return;
        rd_byte <= r;
        cmd({a, 1'b1}, 5'h03);
        cmd(8'h00, 5'h06);
        bus(1'b0, ADDR_RXDATA, 32'h0);
        check_val("first read byte", {24'h0, r}, s);
        cmd(8'h00, 5'h1E);
        bus(1'b0, ADDR_RXDATA, 32'h0);
        check_val("last read byte", {24'h0, r + 8'h01}, s);
    endtask : round

    // A rival pulls data low during a released data bit, then ends its message with a Stop.
    task automatic lose_arbitration();
        cmd({SLV, 1'b0}, 5'h03);
        bus(1'b1, ADDR_TXDATA, 32'hFF);
        bus(1'b1, ADDR_CMD, 32'h02);
        repeat (3) @(negedge scl);
        @(posedge ref_clk);
        tb_sda_oe <= 1'b1;
        wait_idle();
        check_val("status after loss", stat_exp(1'b1, 1'b1, 1'b0, 1'b0), s & 32'h16);
        check_val("pins after loss", 32'h0, {30'h0, pin_oe});
        bus(1'b1, ADDR_CMD, 32'h01);
        repeat (20 * QTR_TB) @(posedge ref_clk);
        bus(1'b0, ADDR_STATUS, 32'h0);
        check_val("start held off", 32'h1, s & 32'h11);
        check_val("pins while held off", 32'h0, {30'h0, pin_oe});
        tb_sda_oe <= 1'b0;
        wait_idle();
        check_val("start after stop", stat_exp(1'b1, 1'b0, 1'b0, 1'b1), s & 32'h16);
        cmd({SLV, 1'b0}, 5'h03);
        check_val("status after restart", stat_exp(1'b1, 1'b0, 1'b0, 1'b1), s & 32'h1E);
        cmd(8'h00, 5'h08);
    endtask : lose_arbitration
////////////////////////////////////////
    always @(posedge ref_clk)
        if (!rst)
            check_val("pin output value", 32'h0, {30'h0, pin_out});

    initial
    begin
        rst = 1'b1;
        {avs_read, avs_write, tb_sda_oe} = 3'h0;
        {avs_address, avs_writedata} = 37'h0;
        {rd_byte, stretch} = 16'h0;
        err_total = 0;
        n_compared = 0;
        seed = 32'hA490AA3B;
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        foreach (RST_ADDRS[k])
        begin
            bus(1'b0, RST_ADDRS[k], 32'h0);
            check_val("value after reset", 32'h0, s);
        end
        bus(1'b1, ADDR_CMD, 32'h03);
        bus(1'b0, ADDR_STATUS, 32'h0);
        check_val("command while disabled", 32'h0, s);
        check_val("pins while disabled", 32'h0, {30'h0, pin_oe});
        bus(1'b1, ADDR_CTRL, 32'h1);
        round(SLV ^ 7'h01, 8'h5A, 8'h00);
        round(SLV, 8'h80, 8'hFE);
        for (i = 0; i < 4; i++)
        begin
            seed = xs(seed);
            stretch <= {3'h0, seed[28:24]};
            round(SLV, seed[7:0], seed[15:8]);
        end
        lose_arbitration();
        complete_run();
    end

    // Limit well above the expected run of some ten thousand cycles.
    initial
    begin
        #400000;
        err_total++;
        $display("MISMATCH watchdog expected completion seen timeout");
        complete_run();
    end
endmodule : test_ibcb_master
